/* hw/isp_regs.svh */
/*
 Constants of the in-system programming front end: serial opcodes,
 test-port instruction codes, signature, reset values, bit positions.
 Assumes inclusion by bare name from the shifter and front end design files.
*/
`ifndef ISP_REGS_SVH
`define ISP_REGS_SVH
// Serial opcodes
`define OP_PREFIX 8'hAC
`define OP_UNLOCK 8'h53
`define OP_ERASE 8'h80
`define OP_POLL 8'hF0
`define OP_EXT_ADDR 8'h4D
`define OP_LOAD_HI 8'h48
`define OP_LOAD_LO 8'h40
`define OP_LOAD_EE 8'hC1
`define OP_READ_HI 8'h28
`define OP_READ_LO 8'h20
`define OP_WRITE_PAGE 8'h4C
`define OP_WRITE_EE_PAGE 8'hC2
`define OP_READ_FUSE 8'h50
`define OP_READ_LOCK 8'h58
`define SUB_LOW 8'h00
`define SUB_HIGH 8'h08
`define OP_WR_LOCK 8'hE0
`define OP_WR_FUSE_LO 8'hA0
`define OP_WR_FUSE_HI 8'hA8
`define OP_WR_FUSE_EXT 8'hA4
`define BYTE_ZERO 8'h00
`define EE_PAGE_MASK 8'hFC
// Byte slots within an instruction
`define SLOT_B2 2'h1
`define SLOT_B3 2'h2
`define SLOT_B4 2'h3
`define BIT_LAST 3'h7
// Test-port instructions and signature
`define IR_HOLD 4'hC
`define IR_UNLOCK 4'h4
`define IR_CMD 4'h5
`define IR_BYPASS 4'hF
`define IR_CAPTURE 4'h1
`define UNLOCK_SIG 16'hA370
// Reset values and bit positions
`define FUSE_RESET 8'hFF
`define FUSE_HI_RESET 8'hBF
`define TPEN_BIT 6
`define TPD_CLR_CYCLES 2'h2
`endif

/* hw/isp_pkg.sv */
/*
 Types shared by the programming front end modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package isp_pkg;
    typedef enum logic [1:0] {nvm_none, nvm_erase, nvm_prog_page, nvm_ee_page} nvm_op_e;
    typedef enum logic [3:0] {
        ts_reset, ts_idle, ts_sel_dr, ts_cap_dr, ts_sh_dr, ts_ex1_dr, ts_pause_dr,
        ts_ex2_dr, ts_upd_dr, ts_sel_ir, ts_cap_ir, ts_sh_ir, ts_ex1_ir, ts_pause_ir,
        ts_ex2_ir, ts_upd_ir
    } tap_state_e;
endpackage : isp_pkg

/* hw/isp_byte_if.sv */
/*
 Byte carrier between the serial shifter and the system-clock core.
 Assumes rx_byte is stable whenever rx_toggle has settled, and tx_byte
 is stable at each byte boundary of the serial clock.
*/
interface isp_byte_if;
    logic [7:0] rx_byte;
    logic rx_toggle;
    logic [7:0] tx_byte;
    modport shifter (output rx_byte, output rx_toggle, input tx_byte);
    modport core (input rx_byte, input rx_toggle, output tx_byte);
endinterface : isp_byte_if

/* hw/isp_sync2.sv */
/*
 Two flip-flop level synchroniser.
 Assumes d is a level from another clock domain.
*/
module isp_sync2 (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level in and out
    input wire logic d,
    output logic q
);
    logic meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : isp_sync2

/* hw/isp_byte_shifter.sv */
/*
 Serial byte shifter on the programmer's serial clock.
 Assumes srst_n is asserted outside a programming session.
*/
`include "isp_regs.svh"
module isp_byte_shifter (
    // Serial clock domain
    input wire logic sck,
    input wire logic srst_n,
    // Serial pins
    input wire logic mosi,
    output logic miso,
    // Byte carrier
    isp_byte_if.shifter bif
);
    logic [6:0] rx_sh_q;
    logic [2:0] cnt_q;
    logic [7:0] tx_q;

    // ==========================================
    // Receive, most significant bit first
    always_ff @(posedge sck or negedge srst_n) begin
        if (!srst_n) begin
            rx_sh_q <= 7'h00;
            cnt_q <= 3'h0;
            bif.rx_byte <= 8'h00;
            bif.rx_toggle <= 1'b0;
        end else begin
            rx_sh_q <= {rx_sh_q[5:0], mosi};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == `BIT_LAST) begin
                bif.rx_byte <= {rx_sh_q, mosi};
                bif.rx_toggle <= ~bif.rx_toggle;
            end
        end
    end

    // ==========================================
    // Transmit, reply loaded at each byte boundary
    always_ff @(negedge sck or negedge srst_n) begin
        if (!srst_n) begin
            tx_q <= 8'h00;
        end else if (cnt_q == 3'h0) begin
            tx_q <= bif.tx_byte;
        end else begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    assign miso = tx_q[7];
endmodule : isp_byte_shifter

/* hw/isp_programming_front_end.sv */
/*
 In-system programming front end: four-byte serial instruction port,
 test access port with hold-reset, unlock and command registers, page
 buffers, fuse and lock bits, and the request port to the memory.
 Assumes the memory answers nvm_rd_data one cycle after nvm_rd_addr
 changes, and reads the page buffer through nvm_buf_idx.
*/
`include "isp_regs.svh"
module isp_programming_front_end (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // External reset pin
    input wire logic ext_reset_n,
    // Serial programming port
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // Test access port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // Core control register
    input wire logic test_port_disable_set,
    output logic test_port_disable_bit,
    output logic core_reset_hold,
    // Memory request port
    output logic nvm_cmd_valid,
    output isp_pkg::nvm_op_e nvm_cmd_op,
    output logic [23:0] nvm_page_addr,
    output logic [23:0] nvm_rd_addr,
    output logic nvm_rd_hi,
    input wire logic [7:0] nvm_rd_data,
    input wire logic nvm_busy,
    input wire logic [6:0] nvm_buf_idx,
    output logic [15:0] nvm_buf_word,
    output logic [31:0] nvm_ee_buf,
    // Fuse and lock bits, active low
    output logic [7:0] fuse_low,
    output logic [7:0] fuse_high,
    output logic [7:0] fuse_ext,
    output logic [7:0] lock_bits,
    // Status and test-port commands
    output logic prog_mode,
    output logic op_pending_flag,
    output logic tap_prog_mode,
    output logic tap_cmd_strobe,
    output logic [14:0] tap_cmd,
    input wire logic [14:0] tap_result
);
    isp_byte_if bif ();

    logic ext_rst_n_s;
    logic srst_n;
    logic rx_tg_s;
    logic rx_tg_q;
    logic rx_evt;
    logic [1:0] slot_q;
    logic [7:0] b0_q;
    logic [7:0] b1_q;
    logic [7:0] b2_q;
    logic [7:0] ext_addr_q;
    logic reply_q;
    logic [7:0] pbuf_hi [0:127];
    logic [7:0] pbuf_lo [0:127];
    logic [7:0] ebuf_q [0:3];
    logic [1:0] low_cnt_q;
    logic usable;
    logic tp_ok_s;
    logic tap_prog_q;
    logic exec_tg_q;
    logic exec_tg_s;
    logic exec_tg_d_q;
    logic [14:0] tap_cmd_q;
    isp_pkg::tap_state_e ts_q;
    isp_pkg::tap_state_e ts_d;
    logic [3:0] ir_sh_q;
    logic [3:0] ir_q;
    logic [15:0] dr_q;

    // ==========================================
    // Serial side: pin sync and byte shifter
    isp_sync2 u_rst_sync (
        .clk(clk_sys),
        .rst_n(rstn),
        .d(ext_reset_n),
        .q(ext_rst_n_s)
    );

    // Serial port only runs while the external reset is held low
    assign srst_n = rstn & ~ext_rst_n_s;

    isp_byte_shifter u_shifter (
        .sck(sck),
        .srst_n(srst_n),
        .mosi(mosi),
        .miso(miso),
        .bif(bif.shifter)
    );

    isp_sync2 u_rx_sync (
        .clk(clk_sys),
        .rst_n(srst_n),
        .d(bif.rx_toggle),
        .q(rx_tg_s)
    );

    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            rx_tg_q <= 1'b0;
        end else begin
            rx_tg_q <= rx_tg_s;
        end
    end

    assign rx_evt = rx_tg_s ^ rx_tg_q;

    // ==========================================
    // Instruction assembly
    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            slot_q <= 2'h0;
            b0_q <= 8'h00;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
        end else if (rx_evt) begin
            slot_q <= slot_q + 2'h1;
            case (slot_q)
                2'h0: b0_q <= bif.rx_byte;
                `SLOT_B2: b1_q <= bif.rx_byte;
                `SLOT_B3: b2_q <= bif.rx_byte;
                default: b2_q <= b2_q;
            endcase
        end
    end

    // ==========================================
    // Reply byte for the next slot
    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            reply_q <= 1'b0;
            nvm_rd_addr <= 24'h000000;
            nvm_rd_hi <= 1'b0;
        end else begin
            reply_q <= rx_evt && slot_q == `SLOT_B3;
            if (rx_evt && slot_q == `SLOT_B3) begin
                nvm_rd_addr <= {ext_addr_q, b1_q, bif.rx_byte};
                nvm_rd_hi <= b0_q == `OP_READ_HI;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            bif.tx_byte <= 8'h00;
        end else if (rx_evt && slot_q == `SLOT_B2) begin
            bif.tx_byte <= bif.rx_byte;
        end else if (rx_evt) begin
            bif.tx_byte <= `BYTE_ZERO;
        end else if (reply_q) begin
            case (b0_q)
                `OP_POLL: bif.tx_byte <= {7'h00, op_pending_flag};
                `OP_READ_HI, `OP_READ_LO: bif.tx_byte <= nvm_rd_data;
                `OP_READ_FUSE: bif.tx_byte <= (b1_q == `SUB_HIGH) ? fuse_ext : fuse_low;
                `OP_READ_LOCK: bif.tx_byte <= (b1_q == `SUB_HIGH) ? fuse_high : lock_bits;
                default: bif.tx_byte <= `BYTE_ZERO;
            endcase
        end
    end

    // ==========================================
    // Programming mode entry
    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            prog_mode <= 1'b0;
        end else if (rx_evt && slot_q == `SLOT_B4 && b0_q == `OP_PREFIX
                     && b1_q == `OP_UNLOCK) begin
            prog_mode <= 1'b1;
        end
    end

    // ==========================================
    // Extended address and fuse bits
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ext_addr_q <= 8'h00;
            fuse_low <= `FUSE_RESET;
            fuse_high <= `FUSE_HI_RESET;
            fuse_ext <= `FUSE_RESET;
            lock_bits <= `FUSE_RESET;
        end else if (rx_evt && slot_q == `SLOT_B4 && prog_mode) begin
            if (b0_q == `OP_EXT_ADDR) begin
                ext_addr_q <= b2_q;
            end
            if (b0_q == `OP_PREFIX) begin
                case (b1_q)
                    `OP_WR_LOCK: lock_bits <= bif.rx_byte;
                    `OP_WR_FUSE_LO: fuse_low <= bif.rx_byte;
                    `OP_WR_FUSE_HI: fuse_high <= bif.rx_byte;
                    `OP_WR_FUSE_EXT: fuse_ext <= bif.rx_byte;
                    default: lock_bits <= lock_bits;
                endcase
            end
        end
    end

    // ==========================================
    // Page buffers
    always_ff @(posedge clk_sys) begin
        if (rx_evt && slot_q == `SLOT_B4 && prog_mode) begin
            if (b0_q == `OP_LOAD_HI) begin
                pbuf_hi[b2_q[6:0]] <= bif.rx_byte;
            end
            if (b0_q == `OP_LOAD_LO) begin
                pbuf_lo[b2_q[6:0]] <= bif.rx_byte;
            end
            if (b0_q == `OP_LOAD_EE) begin
                ebuf_q[b2_q[1:0]] <= bif.rx_byte;
            end
        end
        nvm_buf_word <= {pbuf_hi[nvm_buf_idx], pbuf_lo[nvm_buf_idx]};
    end

    assign nvm_ee_buf = {ebuf_q[3], ebuf_q[2], ebuf_q[1], ebuf_q[0]};

    // ==========================================
    // Commit and erase requests
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            nvm_cmd_valid <= 1'b0;
            nvm_cmd_op <= isp_pkg::nvm_none;
            nvm_page_addr <= 24'h000000;
        end else begin
            nvm_cmd_valid <= 1'b0;
            if (rx_evt && slot_q == `SLOT_B4 && prog_mode) begin
                if (b0_q == `OP_PREFIX && b1_q == `OP_ERASE) begin
                    nvm_cmd_valid <= 1'b1;
                    nvm_cmd_op <= isp_pkg::nvm_erase;
                end
                if (b0_q == `OP_WRITE_PAGE) begin
                    nvm_cmd_valid <= 1'b1;
                    nvm_cmd_op <= isp_pkg::nvm_prog_page;
                    nvm_page_addr <= {ext_addr_q, b1_q, b2_q};
                end
                if (b0_q == `OP_WRITE_EE_PAGE) begin
                    nvm_cmd_valid <= 1'b1;
                    nvm_cmd_op <= isp_pkg::nvm_ee_page;
                    nvm_page_addr <= {8'h00, b1_q, b2_q & `EE_PAGE_MASK};
                end
            end
        end
    end

    assign op_pending_flag = nvm_busy | nvm_cmd_valid;

    // ==========================================
    // Test-port disable bit
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            low_cnt_q <= 2'h0;
            test_port_disable_bit <= 1'b0;
        end else begin
            low_cnt_q <= ext_rst_n_s ? 2'h0
                : (low_cnt_q == `TPD_CLR_CYCLES) ? low_cnt_q : low_cnt_q + 2'h1;
            if (test_port_disable_set) begin
                test_port_disable_bit <= 1'b1;
            end else if (low_cnt_q == `TPD_CLR_CYCLES) begin
                test_port_disable_bit <= 1'b0;
            end
        end
    end

    assign usable = ~fuse_high[`TPEN_BIT] & ~test_port_disable_bit;

    // ==========================================
    // Test access port controller
    isp_sync2 u_tp_sync (
        .clk(tck),
        .rst_n(rstn),
        .d(usable),
        .q(tp_ok_s)
    );

    always_comb begin
        ts_d = ts_q;
        case (ts_q)
            isp_pkg::ts_reset: ts_d = tms ? isp_pkg::ts_reset : isp_pkg::ts_idle;
            isp_pkg::ts_idle: ts_d = tms ? isp_pkg::ts_sel_dr : isp_pkg::ts_idle;
            isp_pkg::ts_sel_dr: ts_d = tms ? isp_pkg::ts_sel_ir : isp_pkg::ts_cap_dr;
            isp_pkg::ts_cap_dr: ts_d = tms ? isp_pkg::ts_ex1_dr : isp_pkg::ts_sh_dr;
            isp_pkg::ts_sh_dr: ts_d = tms ? isp_pkg::ts_ex1_dr : isp_pkg::ts_sh_dr;
            isp_pkg::ts_ex1_dr: ts_d = tms ? isp_pkg::ts_upd_dr : isp_pkg::ts_pause_dr;
            isp_pkg::ts_pause_dr: ts_d = tms ? isp_pkg::ts_ex2_dr : isp_pkg::ts_pause_dr;
            isp_pkg::ts_ex2_dr: ts_d = tms ? isp_pkg::ts_upd_dr : isp_pkg::ts_sh_dr;
            isp_pkg::ts_upd_dr: ts_d = tms ? isp_pkg::ts_sel_dr : isp_pkg::ts_idle;
            isp_pkg::ts_sel_ir: ts_d = tms ? isp_pkg::ts_reset : isp_pkg::ts_cap_ir;
            isp_pkg::ts_cap_ir: ts_d = tms ? isp_pkg::ts_ex1_ir : isp_pkg::ts_sh_ir;
            isp_pkg::ts_sh_ir: ts_d = tms ? isp_pkg::ts_ex1_ir : isp_pkg::ts_sh_ir;
            isp_pkg::ts_ex1_ir: ts_d = tms ? isp_pkg::ts_upd_ir : isp_pkg::ts_pause_ir;
            isp_pkg::ts_pause_ir: ts_d = tms ? isp_pkg::ts_ex2_ir : isp_pkg::ts_pause_ir;
            isp_pkg::ts_ex2_ir: ts_d = tms ? isp_pkg::ts_upd_ir : isp_pkg::ts_sh_ir;
            isp_pkg::ts_upd_ir: ts_d = tms ? isp_pkg::ts_sel_dr : isp_pkg::ts_idle;
            default: ts_d = isp_pkg::ts_reset;
        endcase
    end

    // Runs on tck, reset by rstn and held in ts_reset while usable, synchronised to tck, is low
    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            ts_q <= isp_pkg::ts_reset;
        end else if (!tp_ok_s) begin
            ts_q <= isp_pkg::ts_reset;
        end else begin
            ts_q <= ts_d;
        end
    end

    // ==========================================
    // Instruction register
    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            ir_sh_q <= 4'h0;
            ir_q <= `IR_BYPASS;
        end else begin
            case (ts_q)
                isp_pkg::ts_reset: ir_q <= `IR_BYPASS;
                isp_pkg::ts_cap_ir: ir_sh_q <= `IR_CAPTURE;
                isp_pkg::ts_sh_ir: ir_sh_q <= {tdi, ir_sh_q[3:1]};
                isp_pkg::ts_upd_ir: ir_q <= ir_sh_q;
                default: ir_q <= ir_q;
            endcase
        end
    end

    // ==========================================
    // Data registers
    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            dr_q <= 16'h0000;
            core_reset_hold <= 1'b0;
        end else if (ts_q == isp_pkg::ts_cap_dr && ir_q == `IR_CMD) begin
            dr_q <= {1'b0, tap_result};
        end else if (ts_q == isp_pkg::ts_sh_dr) begin
            case (ir_q)
                `IR_HOLD: core_reset_hold <= tdi;
                `IR_UNLOCK: dr_q <= {tdi, dr_q[15:1]};
                `IR_CMD: dr_q <= {1'b0, tdi, dr_q[14:1]};
                default: dr_q <= {dr_q[15:1], tdi};
            endcase
        end
    end

    // ==========================================
    // Unlock, command update and execution
    always_ff @(posedge tck or negedge rstn) begin
        if (!rstn) begin
            tap_prog_q <= 1'b0;
            tap_cmd_q <= 15'h0000;
            exec_tg_q <= 1'b0;
        end else begin
            if (ts_q == isp_pkg::ts_upd_dr && ir_q == `IR_UNLOCK) begin
                tap_prog_q <= dr_q == `UNLOCK_SIG;
            end
            if (ts_q == isp_pkg::ts_upd_dr && ir_q == `IR_CMD && tap_prog_q) begin
                tap_cmd_q <= dr_q[14:0];
            end
            if (ts_q == isp_pkg::ts_idle && ir_q == `IR_CMD && tap_prog_q) begin
                exec_tg_q <= ~exec_tg_q;
            end
        end
    end

    // ==========================================
    // Output on the falling test clock
    always_ff @(negedge tck or negedge rstn) begin
        if (!rstn) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo_oe <= ts_q == isp_pkg::ts_sh_dr || ts_q == isp_pkg::ts_sh_ir;
            if (ts_q == isp_pkg::ts_sh_ir) begin
                tdo <= ir_sh_q[0];
            end else if (ir_q == `IR_HOLD) begin
                tdo <= core_reset_hold;
            end else begin
                tdo <= dr_q[0];
            end
        end
    end

    // ==========================================
    // Command crossing into the system clock
    isp_sync2 u_exec_sync (
        .clk(clk_sys),
        .rst_n(rstn),
        .d(exec_tg_q),
        .q(exec_tg_s)
    );

    isp_sync2 u_mode_sync (
        .clk(clk_sys),
        .rst_n(rstn),
        .d(tap_prog_q),
        .q(tap_prog_mode)
    );

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            exec_tg_d_q <= 1'b0;
            tap_cmd_strobe <= 1'b0;
            tap_cmd <= 15'h0000;
        end else begin
            exec_tg_d_q <= exec_tg_s;
            tap_cmd_strobe <= exec_tg_s ^ exec_tg_d_q;
            if (exec_tg_s ^ exec_tg_d_q) begin
                tap_cmd <= tap_cmd_q;
            end
        end
    end
endmodule : isp_programming_front_end

/* tb/isp_assertions.sv */
/*
 Checker on the top ports of the programming front end.
 Assumes binding to isp_programming_front_end.
*/
module isp_assertions (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ext_reset_n,
    input wire logic sck,
    input wire logic miso,
    input wire logic test_port_disable_set,
    input wire logic test_port_disable_bit,
    input wire logic nvm_cmd_valid,
    input wire isp_pkg::nvm_op_e nvm_cmd_op,
    input wire logic [23:0] nvm_page_addr,
    input wire logic nvm_busy,
    input wire logic [7:0] fuse_high,
    input wire logic [7:0] lock_bits,
    input wire logic prog_mode,
    input wire logic op_pending_flag
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    pend_flag_a: assert property (op_pending_flag == (nvm_busy || nvm_cmd_valid))
        else $error("pending flag wrong");
    cmd_pulse_a: assert property (nvm_cmd_valid |=> !nvm_cmd_valid)
        else $error("command strobe too long");
    cmd_kind_a: assert property (nvm_cmd_valid |-> nvm_cmd_op != isp_pkg::nvm_none)
        else $error("command without kind");
    cmd_locked_a: assert property (nvm_cmd_valid |-> prog_mode)
        else $error("command while locked");
    ee_align_a: assert property (nvm_cmd_valid && nvm_cmd_op == isp_pkg::nvm_ee_page
        |-> nvm_page_addr[1:0] == 2'h0 && nvm_page_addr[23:16] == 8'h00)
        else $error("eeprom page misaligned");
    fuse_hold_a: assert property (!prog_mode && !$past(prog_mode)
        |-> $stable({fuse_high, lock_bits})) else $error("fuse changed while locked");
    tpd_clear_a: assert property ((!ext_reset_n && !test_port_disable_set)[*8]
        |-> !test_port_disable_bit) else $error("disable bit not cleared");
    tpd_set_a: assert property (test_port_disable_set |-> ##[1:2] test_port_disable_bit)
        else $error("disable bit not set");
    miso_edge_a: assert property ($changed(miso) |-> !sck)
        else $error("serial out moved while clock high");
endmodule : isp_assertions
bind isp_programming_front_end isp_assertions chk (.*);

/* tb/isp_prog_model.sv */
/*
 Serial programmer: sends one four-byte instruction, collects the reply.
 Assumes the caller keeps instructions back to back.
*/
module isp_prog_model (
    input wire logic clk_sys,
    input wire logic miso,
    output logic sck,
    output logic mosi
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
    end
    // Clock stands low between frames
    task automatic xfer(input logic [31:0] ins, output logic [31:0] rep);
        for (int i = 31; i >= 0; i--) begin
            mosi = ins[i];
            repeat (10) @(negedge clk_sys);
            sck = 1'b1;
            rep[i] = miso;
            repeat (10) @(negedge clk_sys);
            sck = 1'b0;
        end
        mosi = ~mosi;
    endtask : xfer
endmodule : isp_prog_model

/* tb/isp_programming_front_end_tb.sv */
/*
 Testbench of the programming front end, serial sessions and disable bit.
 Assumes the memory model below answers reads and stays busy after commands.
*/
module isp_programming_front_end_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, rstn, ext_reset_n, sck, mosi, miso, tck, tms, tdi, tdo, tdo_oe;
    logic test_port_disable_set, test_port_disable_bit, core_reset_hold, nvm_cmd_valid;
    isp_pkg::nvm_op_e nvm_cmd_op, last_op;
    logic [23:0] nvm_page_addr, nvm_rd_addr, last_addr;
    logic nvm_rd_hi, nvm_busy, prog_mode, op_pending_flag, tap_prog_mode, tap_cmd_strobe;
    logic [7:0] nvm_rd_data, fuse_low, fuse_high, fuse_ext, lock_bits;
    logic [6:0] nvm_buf_idx;
    logic [15:0] nvm_buf_word;
    logic [31:0] nvm_ee_buf, rep;
    logic [14:0] tap_cmd, tap_result;
    int error_cnt, cmp_count, cyc, busy_cnt, stb_cnt, base;
    logic [31:0] tq, oq;
    localparam logic [31:0] wr_sel = 32'hE0A0A8A4;
    localparam logic [63:0] rd_sel = 64'h5800500058085008;
    localparam logic [31:0] fval = 32'hFCF09FFE;
    isp_programming_front_end uut (.*);
    isp_prog_model prog (.clk_sys(clk_sys), .miso(miso), .sck(sck), .mosi(mosi));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        tck = 1'b0;
        forever #32 tck = ~tck;
    end
    // Memory model and cycle limit
    always @(negedge clk_sys) begin
        nvm_rd_data <= nvm_rd_addr[7:0] ^ {nvm_rd_hi, 7'h00};
        busy_cnt <= nvm_cmd_valid ? 1200 : (busy_cnt > 0 ? busy_cnt - 1 : 0);
        nvm_busy <= busy_cnt > 1;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            close_out();
        end
    end
    always @(posedge clk_sys) begin
        stb_cnt <= stb_cnt + tap_cmd_strobe;
        if (nvm_cmd_valid) begin
            last_op <= nvm_cmd_op;
            last_addr <= nvm_page_addr;
        end
    end
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic poll_idle();
        for (int n = 0; n < 20; n++) begin
            prog.xfer(32'hF0000000, rep);
            if (rep[0] === 1'b0) return;
        end
        check(1, 0);
    endtask : poll_idle
    // Test port: tms and tdi in time order, tdo and tdo_oe seen at each rising tck
    task automatic tap_io(input logic [31:0] t, input logic [31:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge tck);
            {tms, tdi} = {t[i], d[i]};
            @(posedge tck);
            {tq[i], oq[i]} = {tdo, tdo_oe};
        end
    endtask : tap_io
    // Idle to idle through one register scan, LSB first
    task automatic tap_reg(input bit ir, input logic [15:0] v, input int n);
        tap_io((32'h3 << (n + 2 + ir)) | (ir ? 32'h3 : 32'h1), 32'(v) << (3 + ir), n + 5 + ir);
    endtask : tap_reg
    // ========
    // Main sequence
    initial begin
        {rstn, ext_reset_n, tms, tdi, test_port_disable_set} = 5'h0C;
        {nvm_buf_idx, tap_result, nvm_busy, nvm_rd_data} = {7'h03, 15'h2B6D, 1'b0, 8'h00};
        {cyc, busy_cnt, error_cnt, cmp_count} = '0;
        repeat (6) @(negedge clk_sys);
        rstn = 1'b1;
        check({fuse_low, fuse_high, fuse_ext, lock_bits}, 32'hFFBFFFFF);
        ext_reset_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        prog.xfer(32'hAC530000, rep);
        check(rep[15:8], 8'h53);
        repeat (5) @(negedge clk_sys);
        check(prog_mode, 1);
        prog.xfer(32'h4D000200, rep);
        prog.xfer(32'h28000500, rep);
        check({nvm_rd_hi, nvm_rd_addr}, 25'h1020005);
        check(rep[7:0], 8'h85);
        prog.xfer(32'h20000500, rep);
        check(rep[7:0], 8'h05);
        $display("reads done");
        prog.xfer(32'h4000035A, rep);
        prog.xfer(32'h480003A5, rep);
        check(nvm_buf_word, 16'hA55A);
        prog.xfer(32'h4C004300, rep);
        repeat (5) @(negedge clk_sys);
        check({last_op, last_addr}, {isp_pkg::nvm_prog_page, 24'h020043});
        prog.xfer(32'hF0000000, rep);
        check(rep[0], 1'b1);
        poll_idle();
        prog.xfer(32'hC1000277, rep);
        prog.xfer(32'hC2004700, rep);
        repeat (5) @(negedge clk_sys);
        check({last_op, last_addr, nvm_ee_buf[23:16]}, {2'h3, 24'h000044, 8'h77});
        poll_idle();
        $display("pages done");
        for (int k = 3; k >= 0; k--) begin
            prog.xfer({8'hAC, wr_sel[8*k +: 8], 8'h00, fval[8*k +: 8]}, rep);
            poll_idle();
            prog.xfer({rd_sel[16*k +: 16], 16'h0000}, rep);
            check(rep[7:0], fval[8*k +: 8]);
        end
        check({lock_bits, fuse_low, fuse_high, fuse_ext}, fval);
        prog.xfer(32'hAC800000, rep);
        repeat (5) @(negedge clk_sys);
        check(last_op, isp_pkg::nvm_erase);
        poll_idle();
        $display("fuses and erase done");
        ext_reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        check(prog_mode, 0);
        test_port_disable_set = 1'b1;
        @(negedge clk_sys);
        test_port_disable_set = 1'b0;
        repeat (2) @(negedge clk_sys);
        check(test_port_disable_bit, 1);
        ext_reset_n = 1'b0;
        repeat (8) @(negedge clk_sys);
        check(test_port_disable_bit, 0);
        $display("disable bit done");
        tap_io(32'h0, 32'h0, 6);
        tap_reg(1, 16'hC, 4);
        check(tq[7:4], 4'h1);
        tap_reg(0, 16'h1, 1);
        check(core_reset_hold, 1);
        tap_reg(1, 16'h4, 4);
        tap_reg(0, 16'hA370, 16);
        repeat (4) @(negedge clk_sys);
        check(tap_prog_mode, 1);
        tap_reg(1, 16'h5, 4);
        tap_reg(0, 16'h1234, 15);
        check({tq[17:3], oq[19:0]}, {15'h2B6D, 20'h3FFF8});
        base = stb_cnt;
        tap_io(32'h28, 32'h0, 7);
        repeat (6) @(negedge clk_sys);
        check(stb_cnt - base, 4);
        check(tap_cmd, 15'h1234);
        $display("test port done");
        close_out();
    end
endmodule : isp_programming_front_end_tb
